// *** logic/mic_pkg.sv ***
// Shared constants, types and register map of the interrupt controller
// What this block does
// - Eleven sources: five pins, four timer overflows, serial and A/D.
// - Each source has flag, mask and vector; one global enable gates all.
// - Timer B/pin 2, C/3, D/4 and A/D/serial each share a vector.
// - Control bits sit at locations 000h-003h and 022h-023h.
// - Software writes never set a request flag; only the source event does.
// - Reset clears global enable and all flags, sets all masks.
// - Request is flag one with mask zero; serviced only while enable is one.
// - A priority decode array yields the vector of the serviced source.
// - Entry: finish instruction, push two cycles, clear enable after the first, jump on third.
// - Vectors 0002h to 000Eh by priority one to seven.
// - Reset and stop-cancel vector to 0000h; stop-cancel only in stop mode.
// - Entry lowers the stack pointer by four; return raises it by four.
// - Interrupt return sets the enable and restores carry and status.
// - Pins 0,1 set on falling edge; pins 2-4 by a two-bit edge code.
// - Each timer flag is set by that timer's overflow.
package mic_pkg;

    localparam int NSRC = 11;
    localparam int NGRP = 7;

    // Register indices; the APB byte address is four times the index
    localparam logic [9:0] IDX_CTL0 = 10'h000;
    localparam logic [9:0] IDX_CTL1 = 10'h001;
    localparam logic [9:0] IDX_CTL2 = 10'h002;
    localparam logic [9:0] IDX_CTL3 = 10'h003;
    localparam logic [9:0] IDX_CTL22 = 10'h022;
    localparam logic [9:0] IDX_CTL23 = 10'h023;
    localparam logic [9:0] IDX_EDGE1 = 10'h026;
    localparam logic [9:0] IDX_EDGE2 = 10'h027;
    localparam logic [9:0] IDX_EVT_STAT = 10'h030;
    localparam logic [9:0] IDX_EVT_MASK = 10'h031;

    // Bit positions within location 000h
    localparam int BIT_GIE = 0;
    localparam int BIT_RSP = 1;

    // Source order: pin0, pin1, tmrA, tmrB, pin2, tmrC, pin3, tmrD, pin4, A/D, serial
    localparam logic [9:0] SRC_REG [NSRC] = '{IDX_CTL0, IDX_CTL1, IDX_CTL1, IDX_CTL2,
        IDX_CTL22, IDX_CTL2, IDX_CTL22, IDX_CTL3, IDX_CTL23, IDX_CTL3, IDX_CTL23};
    localparam logic [1:0] SRC_FBIT [NSRC] = '{2'd2, 2'd0, 2'd2, 2'd0, 2'd0, 2'd2,
        2'd2, 2'd0, 2'd0, 2'd2, 2'd2};
    localparam logic [1:0] SRC_MBIT [NSRC] = '{2'd3, 2'd1, 2'd3, 2'd1, 2'd1, 2'd3,
        2'd3, 2'd1, 2'd1, 2'd3, 2'd3};
    localparam logic [2:0] SRC_GRP [NSRC] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd3, 3'd4,
        3'd4, 3'd5, 3'd5, 3'd6, 3'd6};

    // Vectors
    localparam logic [13:0] VEC_RESET = 14'h0000;
    localparam logic [13:0] VEC_BASE = 14'h0002;
    localparam logic [13:0] VEC_STEP = 14'h0002;

    // Stack pointer
    localparam logic [9:0] SP_RST = 10'h3ff;
    localparam logic [9:0] SP_FRAME = 10'h004;

    // Reset values
    localparam logic [NSRC-1:0] FLAG_RST = 11'h000;
    localparam logic [NSRC-1:0] MASK_RST = 11'h7ff;
    localparam logic [3:0] EDGE1_RST = 4'h0;
    localparam logic [1:0] EDGE2_RST = 2'h0;

    // Edge codes
    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_RISE = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // Block event bits: entry done, stop wake, return done
    localparam int EVT_ENTRY = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_RETURN = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CYC1 = 3'b001,
        ST_CYC2 = 3'b010,
        ST_CYC3 = 3'b011,
        ST_WAKE = 3'b100
    } mic_state_t;

    // Frame pushed on entry
    typedef struct packed {
        logic carry_flag;
        logic branch_status_flag;
        logic [13:0] pc;
    } mic_frame_t;

    // Same-clock request pulses from peripherals
    typedef struct packed {
        logic tmr_a;
        logic tmr_b;
        logic tmr_c;
        logic tmr_d;
        logic serial;
        logic adc;
    } mic_periph_t;

endpackage

// *** logic/mic_edge_det.sv ***
// Pin synchroniser and selectable edge detector
`timescale 1ns/10ps
`default_nettype none
module mic_edge_det (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Pin and edge selection
    input wire logic i_pin,
    input wire logic [1:0] i_edge_code,
    // Detected edge
    output logic o_edge
);
    import mic_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
    } mic_edge_st_t;

    mic_edge_st_t s;
    mic_edge_st_t next_s;

    // Idle-high reset level avoids a spurious rising edge after reset
    always_comb begin
        next_s.sync1 = i_pin;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= 3'b111;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        case (i_edge_code)
            EDGE_FALL: o_edge = s.prev & ~s.sync2;
            EDGE_RISE: o_edge = ~s.prev & s.sync2;
            EDGE_BOTH: o_edge = s.prev ^ s.sync2;
            default: o_edge = 1'b0;
        endcase
    end

endmodule // mic_edge_det
`default_nettype wire

// *** logic/mic_prio.sv ***
// Priority decode array: pending sources to vector
`timescale 1ns/10ps
`default_nettype none
module mic_prio (
    // Flags and masks
    input wire logic [10:0] i_flag,
    input wire logic [10:0] i_mask,
    // Decode result
    output logic [6:0] o_grp_req,
    output logic o_valid,
    output logic [13:0] o_vec
);
    import mic_pkg::*;

    always_comb begin
        o_grp_req = '0;
        for (int i = 0; i < NSRC; i++) begin
            // Shared vectors merge their sources into one group
            o_grp_req[SRC_GRP[i]] = o_grp_req[SRC_GRP[i]] | (i_flag[i] & ~i_mask[i]);
        end
    end

    always_comb begin
        o_valid = 1'b0;
        o_vec = VEC_RESET;
        // Walk from lowest priority up so the smallest number wins
        for (int g = NGRP - 1; g >= 0; g--) begin
            if (o_grp_req[g]) begin
                o_valid = 1'b1;
                o_vec = VEC_BASE + VEC_STEP * 14'(g);
            end
        end
    end

endmodule // mic_prio
`default_nettype wire

// *** logic/mic_ctrl.sv ***
// Interrupt controller top: control bits, APB slave and entry sequencer
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module mic_ctrl (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // External pins, asynchronous
    input wire logic i_ext_irq_in_0,
    input wire logic i_ext_irq_in_1,
    input wire logic i_ext_irq_in_2,
    input wire logic i_ext_irq_in_3,
    input wire logic i_ext_irq_in_4,
    input wire logic i_stop_cancel_input,
    // Peripheral request pulses, same clock
    input wire mic_pkg::mic_periph_t i_periph,
    // CPU core side
    input wire logic i_stop_mode,
    input wire logic i_carry_flag,
    input wire logic i_branch_status_flag,
    input wire logic [13:0] i_pc,
    input wire logic i_irq_return_op,
    input wire logic i_ret_carry,
    input wire logic i_ret_status,
    output logic o_finish_instr,
    output logic o_push,
    output var mic_pkg::mic_frame_t o_push_frame,
    output logic o_jump,
    output logic [13:0] o_jump_addr,
    output logic [9:0] o_stack_ptr,
    output logic o_restore,
    output logic o_restore_carry,
    output logic o_restore_status,
    output logic o_global_irq_enable,
    // Block interrupt
    output logic o_irq
);
    import mic_pkg::*;

    typedef struct packed {
        mic_state_t state;
        logic gie;
        logic [NSRC-1:0] flag;
        logic [NSRC-1:0] mask;
        logic [3:0] edge_sel1;
        logic [1:0] edge_sel2;
        logic [9:0] sp;
        logic [13:0] vec;
        mic_frame_t frame;
        logic [2:0] evt;
        logic [2:0] evt_mask;
        logic [31:0] rdata;
        logic slverr;
        logic rst_c;
        logic rst_s;
        logic restore;
    } mic_regs_t;

    mic_regs_t s;
    mic_regs_t next_s;

    logic [5:0] pin_edge;
    logic [NSRC-1:0] src_set;
    logic [6:0] grp_req;
    logic prio_valid;
    logic [13:0] prio_vec;
    logic [9:0] idx;
    logic wr_acc;
    logic rd_setup;
    logic accept;
    logic wake;
    logic [31:0] rd_word;
    logic mapped;
    logic [2:0] evt_set;

    // Pin edge detectors; pins 0 and 1 are fixed falling-edge
    mic_edge_det u_edge0 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pin(i_ext_irq_in_0),
        .i_edge_code(EDGE_FALL), .o_edge(pin_edge[0]));
    mic_edge_det u_edge1 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pin(i_ext_irq_in_1),
        .i_edge_code(EDGE_FALL), .o_edge(pin_edge[1]));
    mic_edge_det u_edge2 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pin(i_ext_irq_in_2),
        .i_edge_code(s.edge_sel1[1:0]), .o_edge(pin_edge[2]));
    mic_edge_det u_edge3 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pin(i_ext_irq_in_3),
        .i_edge_code(s.edge_sel1[3:2]), .o_edge(pin_edge[3]));
    mic_edge_det u_edge4 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pin(i_ext_irq_in_4),
        .i_edge_code(s.edge_sel2), .o_edge(pin_edge[4]));
    // Stop-cancel is taken on its rising edge
    mic_edge_det u_edge_stop (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_pin(i_stop_cancel_input), .i_edge_code(EDGE_RISE), .o_edge(pin_edge[5]));

    mic_prio u_prio (
        .i_flag(s.flag),
        .i_mask(s.mask),
        .o_grp_req(grp_req),
        .o_valid(prio_valid),
        .o_vec(prio_vec)
    );

    // Source order follows the package tables
    assign src_set = {i_periph.serial, i_periph.adc, pin_edge[4], i_periph.tmr_d,
        pin_edge[3], i_periph.tmr_c, pin_edge[2], i_periph.tmr_b,
        i_periph.tmr_a, pin_edge[1], pin_edge[0]};

    assign idx = i_paddr[11:2];
    assign wr_acc = i_psel & i_penable & i_pwrite;
    assign rd_setup = i_psel & ~i_penable;
    assign accept = (s.state == ST_IDLE) & prio_valid & s.gie & ~i_stop_mode;
    assign wake = (s.state == ST_IDLE) & i_stop_mode & pin_edge[5];

    // Read-back view of every location
    always_comb begin
        rd_word = '0;
        mapped = 1'b1;
        case (idx)
            IDX_CTL0, IDX_CTL1, IDX_CTL2, IDX_CTL3, IDX_CTL22, IDX_CTL23: begin
                for (int i = 0; i < NSRC; i++) begin
                    if (SRC_REG[i] == idx) begin
                        rd_word[SRC_FBIT[i]] = s.flag[i];
                        rd_word[SRC_MBIT[i]] = s.mask[i];
                    end
                end
                if (idx == IDX_CTL0) begin
                    rd_word[BIT_GIE] = s.gie;
                    rd_word[BIT_RSP] = 1'b1;
                end
            end
            IDX_EDGE1: rd_word[3:0] = s.edge_sel1;
            IDX_EDGE2: rd_word[1:0] = s.edge_sel2;
            IDX_EVT_STAT: rd_word[2:0] = s.evt;
            IDX_EVT_MASK: rd_word[2:0] = s.evt_mask;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.restore = 1'b0;
        evt_set = '0;
        if (rd_setup) begin
            next_s.rdata = i_pwrite ? 32'h0000_0000 : rd_word;
            next_s.slverr = ~mapped;
        end
        // Software writes: a zero clears a flag, a one leaves it alone
        if (wr_acc) begin
            for (int i = 0; i < NSRC; i++) begin
                if (SRC_REG[i] == idx) begin
                    next_s.flag[i] = s.flag[i] & i_pwdata[SRC_FBIT[i]];
                    next_s.mask[i] = i_pwdata[SRC_MBIT[i]];
                end
            end
            case (idx)
                IDX_CTL0: begin
                    next_s.gie = i_pwdata[BIT_GIE];
                    if (!i_pwdata[BIT_RSP]) begin
                        next_s.sp = SP_RST;
                    end
                end
                IDX_EDGE1: next_s.edge_sel1 = i_pwdata[3:0];
                IDX_EDGE2: next_s.edge_sel2 = i_pwdata[1:0];
                IDX_EVT_STAT: next_s.evt = s.evt & ~i_pwdata[2:0];
                IDX_EVT_MASK: next_s.evt_mask = i_pwdata[2:0];
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle software clear
        next_s.flag = next_s.flag | src_set;
        case (s.state)
            ST_IDLE: begin
                if (wake) begin
                    next_s.vec = VEC_RESET;
                    next_s.state = ST_WAKE;
                end else if (accept) begin
                    next_s.vec = prio_vec;
                    next_s.state = ST_CYC1;
                end else if (i_irq_return_op) begin
                    next_s.gie = 1'b1;
                    next_s.rst_c = i_ret_carry;
                    next_s.rst_s = i_ret_status;
                    next_s.restore = 1'b1;
                    next_s.sp = s.sp + SP_FRAME;
                    evt_set[EVT_RETURN] = 1'b1;
                end
            end
            ST_CYC1: begin
                // The CPU finishes its instruction; its state is now final
                next_s.frame = '{i_carry_flag, i_branch_status_flag, i_pc};
                next_s.state = ST_CYC2;
            end
            ST_CYC2: begin
                next_s.gie = 1'b0;
                next_s.state = ST_CYC3;
            end
            ST_CYC3: begin
                next_s.sp = s.sp - SP_FRAME;
                evt_set[EVT_ENTRY] = 1'b1;
                next_s.state = ST_IDLE;
            end
            ST_WAKE: begin
                evt_set[EVT_WAKE] = 1'b1;
                next_s.state = ST_IDLE;
            end
            default: next_s.state = ST_IDLE;
        endcase
        next_s.evt = next_s.evt | evt_set;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= '{ST_IDLE, 1'b0, FLAG_RST, MASK_RST, EDGE1_RST, EDGE2_RST, SP_RST,
                VEC_RESET, '0, 3'b000, 3'b000, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Zero-wait slave: read data is captured in the setup cycle
    assign o_pready = 1'b1;
    assign o_prdata = s.rdata;
    assign o_pslverr = s.slverr;

    assign o_finish_instr = (s.state == ST_CYC1);
    assign o_push = (s.state == ST_CYC2) | (s.state == ST_CYC3);
    assign o_push_frame = s.frame;
    assign o_jump = (s.state == ST_CYC3) | (s.state == ST_WAKE);
    assign o_jump_addr = s.vec;
    assign o_stack_ptr = s.sp;
    assign o_restore = s.restore;
    assign o_restore_carry = s.rst_c;
    assign o_restore_status = s.rst_s;
    assign o_global_irq_enable = s.gie;
    assign o_irq = |(s.evt & s.evt_mask);

    a_reset_state: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(i_rst) |-> !s.gie && s.flag == '0 && s.mask == '1)
        else $error("control bits wrong after reset");

    a_masked_no_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_IDLE && !s.gie) |=> s.state != ST_CYC1)
        else $error("entry started with global enable low");

    a_entry_sequence: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_IDLE && accept) |=> o_finish_instr ##1 (o_push && !o_jump)
        ##1 (o_push && o_jump && !s.gie))
        else $error("entry sequence out of order");

    a_entry_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_IDLE && accept) |-> ##3 (o_jump_addr == $past(prio_vec, 3)))
        else $error("jump address differs from decoded vector");

    a_first_prio: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_IDLE && accept && grp_req[0]) |=> s.vec == VEC_BASE)
        else $error("highest priority source not served first");

    a_sp_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_CYC3) |=> s.sp == $past(s.sp) - SP_FRAME)
        else $error("stack pointer not lowered by four");

    a_return_restore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s.state == ST_IDLE && !accept && !wake && i_irq_return_op) |=>
        (s.gie && o_restore && o_restore_carry == $past(i_ret_carry)
        && s.sp == $past(s.sp) + SP_FRAME))
        else $error("return did not restore state");

    a_flag_hw_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ((s.flag & ~$past(s.flag) & ~$past(src_set)) == '0))
        else $error("request flag set without its event");

    a_stop_wake: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        wake |=> (o_jump && o_jump_addr == VEC_RESET))
        else $error("stop cancel did not vector to zero");

endmodule // mic_ctrl
`default_nettype wire

// *** test/mic_cpu_model.sv ***
// Behavioural CPU core facing the controller: program counter, stack frame, return
`timescale 1ns/10ps
`default_nettype none
module mic_cpu_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // From the controller
    input wire logic i_push,
    input wire logic i_jump,
    input wire logic [13:0] i_jump_addr,
    input wire mic_pkg::mic_frame_t i_push_frame,
    // Bench command: execute an interrupt return
    input wire logic i_ret_req,
    // To the controller
    output logic o_carry_flag,
    output logic o_branch_status_flag,
    output logic [13:0] o_pc,
    output logic o_irq_return_op,
    output logic o_ret_carry,
    output logic o_ret_status
);
    import mic_pkg::*;

    mic_frame_t saved;

    // Carry toggles on every jump so that each pushed frame differs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pc <= 14'h0000;
            o_carry_flag <= 1'b1;
            o_branch_status_flag <= 1'b0;
            o_irq_return_op <= 1'b0;
            o_ret_carry <= 1'b0;
            o_ret_status <= 1'b0;
            saved <= '0;
        end else begin
            o_pc <= i_jump ? i_jump_addr : o_pc + 14'h0001;
            if (i_jump) begin
                o_carry_flag <= ~o_carry_flag;
                o_branch_status_flag <= o_carry_flag;
            end
            if (i_push) begin
                saved <= i_push_frame;
            end
            o_irq_return_op <= i_ret_req;
            o_ret_carry <= saved.carry_flag;
            o_ret_status <= saved.branch_status_flag;
        end
    end
endmodule // mic_cpu_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the interrupt controller over APB
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mic_pkg::*;

    localparam logic [9:0] CTLS [6] = '{IDX_CTL0, IDX_CTL1, IDX_CTL2, IDX_CTL3,
        IDX_CTL22, IDX_CTL23};
    localparam logic [13:0] VEC_TAB [11] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008,
        14'h0008, 14'h000a, 14'h000a, 14'h000c, 14'h000c, 14'h000e, 14'h000e};
    localparam logic [4:0] PIN_TAB [11] = '{5'h01, 5'h02, 5'h00, 5'h00, 5'h04, 5'h00,
        5'h08, 5'h00, 5'h10, 5'h00, 5'h00};
    localparam logic [5:0] PER_TAB [11] = '{6'h00, 6'h00, 6'h20, 6'h10, 6'h00, 6'h08,
        6'h00, 6'h04, 6'h00, 6'h01, 6'h02};

    logic clk, rst, psel, pen, pwr, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r32;
    logic [4:0] pins;
    logic [5:0] per;
    logic stop_cancel_input, stop_mode, ret_req, e1;
    logic fin, push, jump, restore, rcar, rsta, gie, irq, carry, status, iret, retc, rets;
    logic [13:0] pc, jaddr;
    logic [9:0] sp;
    mic_frame_t frame, last_fr;
    int num_errors = 0;
    int checks_done = 0;
    int jumps = 0;
    int j0;

    mic_ctrl u_mic_ctrl (
        .i_sys_clk(clk),
        .i_rst(rst),
        .i_psel(psel),
        .i_penable(pen),
        .i_pwrite(pwr),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .o_prdata(prdata),
        .o_pready(pready),
        .o_pslverr(pslverr),
        .i_ext_irq_in_0(pins[0]),
        .i_ext_irq_in_1(pins[1]),
        .i_ext_irq_in_2(pins[2]),
        .i_ext_irq_in_3(pins[3]),
        .i_ext_irq_in_4(pins[4]),
        .i_stop_cancel_input(stop_cancel_input),
        .i_periph(mic_periph_t'(per)),
        .i_stop_mode(stop_mode),
        .i_carry_flag(carry),
        .i_branch_status_flag(status),
        .i_pc(pc),
        .i_irq_return_op(iret),
        .i_ret_carry(retc),
        .i_ret_status(rets),
        .o_finish_instr(fin),
        .o_push(push),
        .o_push_frame(frame),
        .o_jump(jump),
        .o_jump_addr(jaddr),
        .o_stack_ptr(sp),
        .o_restore(restore),
        .o_restore_carry(rcar),
        .o_restore_status(rsta),
        .o_global_irq_enable(gie),
        .o_irq(irq)
    );

    mic_cpu_model u_mic_cpu_model (
        .i_sys_clk(clk),
        .i_rst(rst),
        .i_push(push),
        .i_jump(jump),
        .i_jump_addr(jaddr),
        .i_push_frame(frame),
        .i_ret_req(ret_req),
        .o_carry_flag(carry),
        .o_branch_status_flag(status),
        .o_pc(pc),
        .o_irq_return_op(iret),
        .o_ret_carry(retc),
        .o_ret_status(rets)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counted mid-cycle so the pulse is seen settled
    always @(negedge clk) begin
        if (jump === 1'b1) begin
            jumps++;
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [3:0] d,
                       output logic [31:0] rd_data, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {28'h0000000, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [3:0] d);
        apb(1'b1, idx, d, r32, e1);
    endtask

    task automatic rd(input string n, input logic [9:0] idx, input logic [3:0] ex);
        apb(1'b0, idx, 4'h0, r32, e1);
        chk(n, r32, {28'h0000000, ex});
        chk(n, 32'(e1), 32'h0);
    endtask

    // Kind 0 waits for entry cycle one, 1 for restore, 2 for a jump
    task automatic await(input int k);
        int n;
        n = 0;
        #1;
        while (n < 40 && !((k == 0 && fin === 1'b1) || (k == 1 && restore === 1'b1)
                || (k == 2 && jump === 1'b1))) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic entry(input logic [13:0] v);
        await(0);
        chk("finish", 32'(fin), 32'h1);
        last_fr = {carry, status, pc};
        tick(1);
        chk("push c2", {30'h0, push, jump}, 32'h2);
        chk("frame", 32'(frame), 32'(last_fr));
        tick(1);
        chk("push c3", {30'h0, push, jump}, 32'h3);
        chk("vector", 32'(jaddr), 32'(v));
        chk("gie off", 32'(gie), 32'h0);
        tick(1);
        chk("sp down", 32'(sp), 32'h3fb);
    endtask

    task automatic ret;
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        await(1);
        chk("restore", 32'(restore), 32'h1);
        chk("gie back", 32'(gie), 32'h1);
        chk("sp up", 32'(sp), 32'h3ff);
        chk("carry back", 32'(rcar), 32'(last_fr.carry_flag));
        chk("status back", 32'(rsta), 32'(last_fr.branch_status_flag));
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pins = 5'h1f;
        per = 6'h00;
        stop_cancel_input = 1'b0;
        stop_mode = 1'b0;
        ret_req = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (CTLS[i]) rd("ctl reset", CTLS[i], 4'ha);
        rd("edge reset", IDX_EDGE1, 4'h0);
        rd("evt mask reset", IDX_EVT_MASK, 4'h0);
        chk("sp reset", 32'(sp), 32'h3ff);
        apb(1'b0, 10'h004, 4'h0, r32, e1);
        chk("unmapped err", 32'(e1), 32'h1);
        wr(IDX_CTL1, 4'hf);
        rd("flag by write", IDX_CTL1, 4'ha);
        // A bare return wraps the pointer, then a cleared reload bit restores it
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        tick(3);
        chk("sp wrap", 32'(sp), 32'h003);
        wr(IDX_CTL0, 4'h8);
        tick(1);
        chk("sp reload", 32'(sp), 32'h3ff);
        $display("test reset done");
        // Pin 2 stays masked here, so only its flag shows the edge code
        for (int c = 0; c < 4; c++) begin
            wr(IDX_EDGE1, 4'(c));
            @(posedge clk) pins[2] <= 1'b0;
            tick(6);
            rd("fall flag", IDX_CTL22, {3'b101, c[0]});
            wr(IDX_CTL22, 4'ha);
            @(posedge clk) pins[2] <= 1'b1;
            tick(6);
            rd("rise flag", IDX_CTL22, {3'b101, c[1]});
            wr(IDX_CTL22, 4'ha);
        end
        wr(IDX_EDGE1, 4'h5);
        wr(IDX_EDGE2, 4'h1);
        $display("test edges done");
        for (int s = 0; s < NSRC; s++) begin
            wr(SRC_REG[s], 4'hf & ~(4'h1 << SRC_MBIT[s]));
            wr(IDX_CTL0, (s == 0) ? 4'h7 : 4'hf);
            @(posedge clk) begin
                pins <= ~PIN_TAB[s];
                per <= PER_TAB[s];
            end
            @(posedge clk) per <= 6'h00;
            entry(VEC_TAB[s]);
            @(posedge clk) pins <= 5'h1f;
            rd("source flag", SRC_REG[s], 4'ha ^ (4'h1 << SRC_MBIT[s]) ^ (4'h1 << SRC_FBIT[s]));
            wr(SRC_REG[s], (s == 0) ? 4'ha : 4'hf & ~(4'h1 << SRC_FBIT[s]));
            ret();
        end
        $display("test sources done");
        wr(IDX_CTL0, 4'ha);
        wr(IDX_CTL1, 4'h5);
        j0 = jumps;
        @(posedge clk) begin
            pins[1] <= 1'b0;
            per <= 6'h20;
        end
        @(posedge clk) per <= 6'h00;
        tick(8);
        rd("both pending", IDX_CTL1, 4'h5);
        chk("held while disabled", 32'(jumps), 32'(j0));
        wr(IDX_CTL0, 4'hb);
        entry(14'h0004);
        @(posedge clk) pins[1] <= 1'b1;
        wr(IDX_CTL1, 4'h4);
        ret();
        entry(14'h0006);
        wr(IDX_CTL1, 4'ha);
        ret();
        $display("test priority done");
        j0 = jumps;
        @(posedge clk) stop_cancel_input <= 1'b1;
        tick(8);
        chk("wake outside stop", 32'(jumps), 32'(j0));
        @(posedge clk) begin
            stop_cancel_input <= 1'b0;
            stop_mode <= 1'b1;
        end
        tick(6);
        @(posedge clk) stop_cancel_input <= 1'b1;
        await(2);
        chk("wake jump", 32'(jump), 32'h1);
        chk("wake vector", 32'(jaddr), 32'h0);
        @(posedge clk) begin
            stop_cancel_input <= 1'b0;
            stop_mode <= 1'b0;
        end
        $display("test stop done");
        rd("event status", IDX_EVT_STAT, 4'h7);
        chk("irq masked", 32'(irq), 32'h0);
        wr(IDX_EVT_MASK, 4'h1);
        tick(2);
        chk("irq raised", 32'(irq), 32'h1);
        wr(IDX_EVT_STAT, 4'h2);
        rd("event w1c", IDX_EVT_STAT, 4'h5);
        wr(IDX_EVT_STAT, 4'h1);
        tick(2);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("test events done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
